// [hw/dcs_regs.svh]
// Register indices, field positions, reset values and mode codes for the drive command block
`ifndef DCS_REGS_SVH
`define DCS_REGS_SVH
`define DCS_IDX_ALARM      16'h603F
`define DCS_IDX_CMD        16'h6040
`define DCS_IDX_STATE      16'h6041
`define DCS_CMD_RESET      16'h0000
`define DCS_ALARM_RESET    16'h0000
`define DCS_B_SWITCH_ON    0
`define DCS_B_EN_VOLT      1
`define DCS_B_QSTOP        2
`define DCS_B_EN_OP        3
`define DCS_B_NEW_SP       4
`define DCS_B_IMMED        5
`define DCS_B_REL          6
`define DCS_B_FAULT_RST    7
`define DCS_B_HALT         8
`define DCS_B_CHG_SP       9
`define DCS_S_WARN         7
`define DCS_S_VOLT         4
`define DCS_S_REMOTE       9
`define DCS_S_TGT          10
`define DCS_S_LIMIT        11
`define DCS_S_B12          12
`define DCS_S_B13          13
`define DCS_S_ABSV         14
`define DCS_MODE_PP        8'h01
`define DCS_MODE_PV        8'h03
`define DCS_MODE_PT        8'h04
`define DCS_MODE_HM        8'h06
`define DCS_MODE_CSP       8'h08
`define DCS_MODE_CSV       8'h09
`define DCS_MODE_CST       8'h0A
`endif

// [hw/dcs_pkg.sv]
// Types for the two ends of the drive command link: drive states for the drive end, access states for the master end
package dcs_pkg;
   typedef enum logic [7:0] {
      DCS_NOT_READY = 8'h01,
      DCS_SW_DIS    = 8'h02,
      DCS_READY     = 8'h04,
      DCS_SW_ON     = 8'h08,
      DCS_OP_EN     = 8'h10,
      DCS_QSTOP     = 8'h20,
      DCS_FLT_REACT = 8'h40,
      DCS_FAULT     = 8'h80
   } dcs_state_t;
   typedef enum logic [2:0] {
      DCS_REG_IDLE  = 3'h1,
      DCS_REG_WRITE = 3'h2,
      DCS_REG_READ  = 3'h4
   } dcs_acc_t;
endpackage

// [hw/dcs_link_if.sv]
// Process data link between the motion controller and the drive
`timescale 1ns/1ps
interface dcs_link_if;
   logic        wr_en;
   logic        rd_en;
   logic [15:0] index;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        rvalid;
   logic        err;
   modport drive (input wr_en, input rd_en, input index, input wdata,
                  output rdata, output rvalid, output err);
   modport master (output wr_en, output rd_en, output index, output wdata,
                   input rdata, input rvalid, input err);
endinterface

// [hw/dcs_master.sv]
// Motion controller end: issues single register writes and reads on the link
`timescale 1ns/1ps
`include "dcs_regs.svh"
module dcs_master (
   input  wire logic         clk_sys,
   input  wire logic         nrst,
   dcs_link_if.master        link,
   input  wire logic         req,
   input  wire logic         req_write,
   input  wire logic [15:0]  req_index,
   input  wire logic [15:0]  req_wdata,
   output logic              busy,
   output logic              done,
   output logic [15:0]       rsp_data,
   output logic              rsp_err
);
   dcs_pkg::dcs_acc_t st_q;
   logic        wr_q;
   logic        rd_q;
   logic [15:0] idx_q;
   logic [15:0] wd_q;

   assign link.wr_en = wr_q;
   assign link.rd_en = rd_q;
   assign link.index = idx_q;
   assign link.wdata = wd_q;

   // One access in flight; requests while busy are ignored
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_q     <= dcs_pkg::DCS_REG_IDLE;
         wr_q     <= 1'b0;
         rd_q     <= 1'b0;
         idx_q    <= 16'h0000;
         wd_q     <= 16'h0000;
         busy     <= 1'b0;
         done     <= 1'b0;
         rsp_data <= 16'h0000;
         rsp_err  <= 1'b0;
      end else begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         done <= 1'b0;
         case (st_q)
            dcs_pkg::DCS_REG_IDLE: begin
               if (req) begin
                  // R3 R4 R7 R8 command words as the caller builds them
                  idx_q <= req_index;
                  wd_q  <= req_wdata;
                  wr_q  <= req_write;
                  rd_q  <= !req_write;
                  busy  <= 1'b1;
                  st_q  <= req_write ? dcs_pkg::DCS_REG_WRITE : dcs_pkg::DCS_REG_READ;
               end
            end
            dcs_pkg::DCS_REG_WRITE, dcs_pkg::DCS_REG_READ: begin
               if (link.rvalid) begin
                  rsp_data <= link.rdata;
                  rsp_err  <= link.err;
                  done     <= 1'b1;
                  busy     <= 1'b0;
                  st_q     <= dcs_pkg::DCS_REG_IDLE;
               end
            end
            default: st_q <= dcs_pkg::DCS_REG_IDLE;
         endcase
      end
   end
endmodule // dcs_master

// [hw/dcs_drive.sv]
// Drive end: command word decode, drive state machine and status word assembly
`timescale 1ns/1ps
`include "dcs_regs.svh"
// Behaviour
// R1 - Read-only alarm code, resets zero, latest alarm
// R2 - Read/write 16-bit command word, resets zero
// R3 - Low nibble decodes shutdown, switch-on, disable, quickstop
// R4 - Pattern 1111 switches on and enables
// R5 - Fault reset only on bit 7 rise
// R6 - Cyclic modes: bit 8 halts motion
// R7 - PP: new point queued after current move
// R8 - PP: bit 5 set applies point immediately
// R9 - PP: bit 9 finishes current target first
// R10 - PP: bit 6 selects absolute or relative
// R11 - PP: bit 8 halts, clear runs
// R12 - PV/PT: bits reserved, bit 8 halts
// R13 - Homing: bit 4 starts or keeps homing
// R14 - Homing: bit 8 halts homing
// R15 - Read-only status word, reserved bits zero
// R16 - Status bit 9 flags remote control active
// R17 - Bit 11 limit active, bit 14 abs valid
// R18 - Status low bits encode drive state
// R19 - Bit 4 main power, bit 7 warning
// R20 - PP: bit 12 acknowledges set point
// R21 - Homing: bits 13,12,10 encode progress
// R22 - Edges found by comparing with previous word
// R23 - Status recomputed every drive cycle
module dcs_drive (
   input  wire logic         clk_sys,
   input  wire logic         nrst,
   dcs_link_if.drive         link,
   input  wire logic [7:0]   op_mode,
   input  wire logic         alarm_set,
   input  wire logic [15:0]  alarm_code,
   input  wire logic         warn_set,
   input  wire logic         fault_react_done,
   input  wire logic         main_power,
   input  wire logic         remote_en,
   input  wire logic         limit_active,
   input  wire logic         abs_valid,
   input  wire logic         move_done,
   input  wire logic         target_reached,
   input  wire logic         speed_zero,
   input  wire logic         homing_done,
   input  wire logic         homing_err,
   output logic              halt_q,
   output logic              sp_start_q,
   output logic              sp_immed_q,
   output logic              sp_finish_q,
   output logic              sp_relative_q,
   output logic              homing_run_q,
   output logic              power_stage_q,
   output logic              alarm_clear_q,
   output logic [15:0]       status_word_q
);
   logic [15:0]         cmd_q;
   logic [15:0]         cmd_prev_q;
   logic [15:0]         alarm_q;
   logic                warn_q;
   logic                sp_ack_q;
   dcs_pkg::dcs_state_t st_q;
   logic [15:0]         sw_d;
   logic [15:0]         rd_d;
   logic                known_d;
   logic                rise4;
   logic                rise7;
   logic                mode_pp;
   logic                mode_hm;
   logic                mode_cyc;
   logic                mode_pvt;

   assign mode_pp  = (op_mode == `DCS_MODE_PP);
   assign mode_hm  = (op_mode == `DCS_MODE_HM);
   assign mode_cyc = (op_mode == `DCS_MODE_CSP) || (op_mode == `DCS_MODE_CSV) ||
                     (op_mode == `DCS_MODE_CST);
   assign mode_pvt = (op_mode == `DCS_MODE_PV) || (op_mode == `DCS_MODE_PT);

   // R22 edge detect against the previous word
   assign rise4 = cmd_q[`DCS_B_NEW_SP] & ~cmd_prev_q[`DCS_B_NEW_SP];
   assign rise7 = cmd_q[`DCS_B_FAULT_RST] & ~cmd_prev_q[`DCS_B_FAULT_RST];

   // R2 command word storage, any value accepted
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cmd_q      <= `DCS_CMD_RESET;
         cmd_prev_q <= `DCS_CMD_RESET;
      end else begin
         cmd_prev_q <= cmd_q;
         if (link.wr_en && link.index == `DCS_IDX_CMD) begin
            cmd_q <= link.wdata;
         end
      end
   end

   // R1 latest alarm code; R5 warning cleared on bit 7 rise only, a new warning wins
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         alarm_q       <= `DCS_ALARM_RESET;
         warn_q        <= 1'b0;
         alarm_clear_q <= 1'b0;
      end else begin
         alarm_clear_q <= rise7;
         if (alarm_set) alarm_q <= alarm_code;
         if (warn_set) begin
            warn_q <= 1'b1;
         end else if (rise7) begin
            warn_q <= 1'b0;
         end
      end
   end

   // R3 R4 drive state machine; fault overrides any command except in the fault state, where a bit 7 rise still leaves
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_q <= dcs_pkg::DCS_NOT_READY;
      end else if (alarm_set && st_q != dcs_pkg::DCS_FAULT) begin
         st_q <= dcs_pkg::DCS_FLT_REACT;
      end else begin
         case (st_q)
            dcs_pkg::DCS_NOT_READY: st_q <= dcs_pkg::DCS_SW_DIS;
            dcs_pkg::DCS_SW_DIS: begin
               if (cmd_q[2:0] == 3'h6) st_q <= dcs_pkg::DCS_READY;
            end
            dcs_pkg::DCS_READY: begin
               if (!cmd_q[`DCS_B_EN_VOLT] || !cmd_q[`DCS_B_QSTOP])
                  st_q <= dcs_pkg::DCS_SW_DIS;
               else if (cmd_q[3:0] == 4'hF) st_q <= dcs_pkg::DCS_OP_EN;
               else if (cmd_q[3:0] == 4'h7) st_q <= dcs_pkg::DCS_SW_ON;
            end
            dcs_pkg::DCS_SW_ON: begin
               if (!cmd_q[`DCS_B_EN_VOLT] || !cmd_q[`DCS_B_QSTOP])
                  st_q <= dcs_pkg::DCS_SW_DIS;
               else if (cmd_q[2:0] == 3'h6) st_q <= dcs_pkg::DCS_READY;
               else if (cmd_q[3:0] == 4'hF) st_q <= dcs_pkg::DCS_OP_EN;
            end
            dcs_pkg::DCS_OP_EN: begin
               if (!cmd_q[`DCS_B_EN_VOLT]) st_q <= dcs_pkg::DCS_SW_DIS;
               else if (!cmd_q[`DCS_B_QSTOP]) st_q <= dcs_pkg::DCS_QSTOP;
               else if (cmd_q[2:0] == 3'h6) st_q <= dcs_pkg::DCS_READY;
               else if (cmd_q[3:0] == 4'h7) st_q <= dcs_pkg::DCS_SW_ON;
            end
            dcs_pkg::DCS_QSTOP: begin
               if (!cmd_q[`DCS_B_EN_VOLT] || speed_zero) st_q <= dcs_pkg::DCS_SW_DIS;
            end
            dcs_pkg::DCS_FLT_REACT: begin
               if (fault_react_done) st_q <= dcs_pkg::DCS_FAULT;
            end
            dcs_pkg::DCS_FAULT: begin
               // R5 leave fault on the reset edge only
               if (rise7) st_q <= dcs_pkg::DCS_SW_DIS;
            end
            default: st_q <= dcs_pkg::DCS_NOT_READY;
         endcase
      end
   end

   // Mode actions; homing run and power stage are gated on operation enabled, the others act in any state
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         halt_q        <= 1'b0;
         sp_start_q    <= 1'b0;
         sp_immed_q    <= 1'b0;
         sp_finish_q   <= 1'b0;
         sp_relative_q <= 1'b0;
         homing_run_q  <= 1'b0;
         power_stage_q <= 1'b0;
      end else begin
         // R6 R11 R12 R14 halt in every motion mode
         halt_q        <= cmd_q[`DCS_B_HALT] & (mode_pp | mode_hm | mode_cyc | mode_pvt);
         power_stage_q <= (st_q == dcs_pkg::DCS_OP_EN);
         // R10 absolute or relative target
         sp_relative_q <= mode_pp & cmd_q[`DCS_B_REL];
         // R7 queued set point
         sp_start_q    <= mode_pp & rise4 & ~cmd_q[`DCS_B_IMMED] & ~cmd_q[`DCS_B_CHG_SP];
         // R8 immediate change, bit 9 ignored
         sp_immed_q    <= mode_pp & rise4 & cmd_q[`DCS_B_IMMED];
         // R9 finish current target first
         sp_finish_q   <= mode_pp & rise4 & ~cmd_q[`DCS_B_IMMED] & cmd_q[`DCS_B_CHG_SP];
         // R13 R14 homing runs while bit 4 held and not halted
         homing_run_q  <= mode_hm & cmd_q[`DCS_B_NEW_SP] & ~cmd_q[`DCS_B_HALT] &
                          (st_q == dcs_pkg::DCS_OP_EN);
      end
   end

   // R20 set-point acknowledge: set on take-up, cleared when move completes
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sp_ack_q <= 1'b0;
      end else begin
         if (mode_pp && rise4) sp_ack_q <= 1'b1;
         else if (!cmd_q[`DCS_B_NEW_SP] || move_done) sp_ack_q <= 1'b0;
      end
   end

   // R23 status assembled from present conditions each cycle
   always_comb begin
      sw_d = 16'h0000;
      // R18 drive state flags
      case (st_q)
         dcs_pkg::DCS_NOT_READY: sw_d[6:0] = 7'h00;
         dcs_pkg::DCS_SW_DIS:    sw_d[6:0] = 7'h40;
         dcs_pkg::DCS_READY:     sw_d[6:0] = 7'h21;
         dcs_pkg::DCS_SW_ON:     sw_d[6:0] = 7'h23;
         dcs_pkg::DCS_OP_EN:     sw_d[6:0] = 7'h27;
         dcs_pkg::DCS_QSTOP:     sw_d[6:0] = 7'h07;
         dcs_pkg::DCS_FLT_REACT: sw_d[6:0] = 7'h0F;
         dcs_pkg::DCS_FAULT:     sw_d[6:0] = 7'h08;
         default:                sw_d[6:0] = 7'h00;
      endcase
      // R19 power and warning
      sw_d[`DCS_S_VOLT]   = main_power;
      sw_d[`DCS_S_WARN]   = warn_q;
      // R16 remote
      sw_d[`DCS_S_REMOTE] = remote_en;
      // R17 limit and absolute valid
      sw_d[`DCS_S_LIMIT]  = limit_active;
      sw_d[`DCS_S_ABSV]   = abs_valid;
      if (mode_hm) begin
         // R21 homing progress code
         sw_d[`DCS_S_B13] = homing_err;
         sw_d[`DCS_S_B12] = ~homing_err & homing_done;
         sw_d[`DCS_S_TGT] = homing_err ? speed_zero :
                            (homing_done ? target_reached : ~homing_run_q);
      end else if (mode_pp) begin
         sw_d[`DCS_S_B12] = sp_ack_q;
         sw_d[`DCS_S_TGT] = cmd_q[`DCS_B_HALT] ? speed_zero : target_reached;
      end else if (mode_pvt) begin
         sw_d[`DCS_S_B12] = speed_zero & (op_mode == `DCS_MODE_PV);
         sw_d[`DCS_S_TGT] = cmd_q[`DCS_B_HALT] ? speed_zero : target_reached;
      end else if (mode_cyc) begin
         sw_d[`DCS_S_TGT] = target_reached;
      end
   end

   // R15 register read mux; unknown index answers error
   always_comb begin
      known_d = 1'b1;
      case (link.index)
         `DCS_IDX_ALARM: rd_d = alarm_q;
         `DCS_IDX_CMD:   rd_d = cmd_q;
         `DCS_IDX_STATE: rd_d = status_word_q;
         default: begin
            rd_d    = 16'h0000;
            known_d = 1'b0;
         end
      endcase
   end

   // Answer one cycle after each access; writes to read-only words are refused
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         status_word_q <= 16'h0000;
         link.rdata    <= 16'h0000;
         link.rvalid   <= 1'b0;
         link.err      <= 1'b0;
      end else begin
         status_word_q <= sw_d;
         link.rvalid   <= link.wr_en | link.rd_en;
         link.rdata    <= link.rd_en ? rd_d : 16'h0000;
         link.err      <= (link.wr_en | link.rd_en) &
                          (~known_d | (link.wr_en & link.index != `DCS_IDX_CMD));
      end
   end
endmodule // dcs_drive

// [bench/dcs_link_checker.sv]
// Protocol checker watching the link between the two ends
`timescale 1ns/1ps
`include "dcs_regs.svh"
module dcs_link_checker (
   input wire logic        clk_sys,
   input wire logic        nrst,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [15:0] index,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic        rvalid,
   input wire logic        err
);
   logic [15:0] cmd_q;
   logic        known;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // Shadow of the last command word written, so read-back can be judged
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst)
         cmd_q <= 16'h0000;
      else if (wr_en && index == `DCS_IDX_CMD)
         cmd_q <= wdata;
   end
   // Indices that answer a read without refusal
   assign known = index == `DCS_IDX_ALARM || index == `DCS_IDX_CMD || index == `DCS_IDX_STATE;
   chk_ans_one_pulse: assert property ((wr_en || rd_en) |=> rvalid ##1 !rvalid)
      else $error("answer not a single pulse");
   chk_ans_has_cause: assert property (rvalid |-> $past(wr_en || rd_en))
      else $error("answer without access");
   chk_err_with_ans: assert property (err |-> rvalid)
      else $error("refusal outside answer");
   chk_alarm_ro: assert property (wr_en && index == `DCS_IDX_ALARM |=> err)
      else $error("alarm code write accepted");
   chk_state_ro: assert property (wr_en && index == `DCS_IDX_STATE |=> err)
      else $error("status word write accepted");
   chk_cmd_accept: assert property (wr_en && index == `DCS_IDX_CMD |=> !err && rdata == 16'h0000)
      else $error("command write refused");
   chk_cmd_readback: assert property (rd_en && index == `DCS_IDX_CMD |=> rdata == cmd_q && !err)
      else $error("command read-back differs");
   chk_unknown_read: assert property (rd_en && !known |=> err && rdata == 16'h0000)
      else $error("unknown index not refused");
   chk_status_rsvd: assert property (rd_en && index == `DCS_IDX_STATE |=> rdata[8] == 1'b0
                                     && rdata[15] == 1'b0 && !err)
      else $error("status reserved bits set");
endmodule // dcs_link_checker

// [bench/drive_control_status_word_tb.sv]
// Self-checking bench joining both ends of the drive command link
`timescale 1ns/1ps
`include "dcs_regs.svh"
module drive_control_status_word_tb;
   logic        clk_sys, nrst, req, req_write, done, rsp_err;
   logic        halt_q, sp_start_q, sp_immed_q, sp_finish_q, sp_relative_q;
   logic        homing_run_q, power_stage_q, alarm_clear_q, e;
   logic [7:0]  op_mode;
   // Drive inputs: alarm, warn, reaction done, power, remote, limit, abs, zero, hdone, herr,
   // move done, target reached
   logic [11:0] dv;
   logic [15:0] req_index, req_wdata, rsp_data, status_word_q, acode, r;
   int          err_count = 0, n_checks = 0, n_clr = 0, n_imm = 0, n_fin = 0, n_st = 0;
   localparam logic [15:0] SC [8] = '{16'h0006, 16'h0007, 16'h000F, 16'h0007, 16'h000F,
                                      16'h000D, 16'h0006, 16'h000F};
   localparam logic [15:0] SE [8] = '{16'h4A31, 16'h4A33, 16'h4A37, 16'h4A33, 16'h4A37,
                                      16'h4A50, 16'h4A31, 16'h4A37};
   localparam logic [7:0]  MD [7] = '{`DCS_MODE_PP, `DCS_MODE_PV, `DCS_MODE_PT, `DCS_MODE_CSP,
                                      `DCS_MODE_CSV, `DCS_MODE_CST, `DCS_MODE_HM};
   dcs_link_if link ();
   dcs_master u_dcs_master (.clk_sys(clk_sys), .nrst(nrst), .link(link), .req(req),
      .req_write(req_write), .req_index(req_index), .req_wdata(req_wdata), .busy(),
      .done(done), .rsp_data(rsp_data), .rsp_err(rsp_err));
   dcs_drive u_dcs_drive (.clk_sys(clk_sys), .nrst(nrst), .link(link), .op_mode(op_mode),
      .alarm_set(dv[0]), .alarm_code(acode), .warn_set(dv[1]), .fault_react_done(dv[2]),
      .main_power(dv[3]), .remote_en(dv[4]), .limit_active(dv[5]), .abs_valid(dv[6]),
      .move_done(dv[10]), .target_reached(dv[11]), .speed_zero(dv[7]), .homing_done(dv[8]),
      .homing_err(dv[9]), .halt_q(halt_q), .sp_start_q(sp_start_q), .sp_immed_q(sp_immed_q),
      .sp_finish_q(sp_finish_q), .sp_relative_q(sp_relative_q), .homing_run_q(homing_run_q),
      .power_stage_q(power_stage_q), .alarm_clear_q(alarm_clear_q),
      .status_word_q(status_word_q));
   dcs_link_checker u_dcs_link_checker (.clk_sys(clk_sys), .nrst(nrst), .wr_en(link.wr_en),
      .rd_en(link.rd_en), .index(link.index), .wdata(link.wdata), .rdata(link.rdata),
      .rvalid(link.rvalid), .err(link.err));
   // Free-running system clock
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Pulse outputs are counted, since a missed or doubled pulse is the likely fault
   always @(posedge clk_sys) begin
      if (alarm_clear_q === 1'b1) n_clr++;
      if (sp_immed_q === 1'b1) n_imm++;
      if (sp_finish_q === 1'b1) n_fin++;
      if (sp_start_q === 1'b1) n_st++;
   end
   task automatic finish_test;
      if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Waits end just past the edge so registered outputs have landed
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   // One access through the master end; a lost done counts as a mismatch
   task automatic acc(input logic w, input logic [15:0] idx, wd);
      int n;
      n = 0;
      @(posedge clk_sys);
      req <= 1'b1;
      req_write <= w;
      req_index <= idx;
      req_wdata <= wd;
      @(posedge clk_sys);
      req <= 1'b0;
      do begin
         @(posedge clk_sys);
         #1 n++;
      end while (done !== 1'b1 && n < 9);
      if (n >= 9) err_count++;
      r = rsp_data;
      e = rsp_err;
   endtask
   task automatic wr(input logic [15:0] idx, d, input logic ee);
      acc(1'b1, idx, d);
      cmp(16'(e), 16'(ee));
   endtask
   task automatic rdc(input logic [15:0] idx, ed, input logic ee);
      acc(1'b0, idx, 16'h0000);
      cmp(r, ed);
      cmp(16'(e), 16'(ee));
   endtask
   task automatic cmd(input logic [15:0] d);
      wr(`DCS_IDX_CMD, d, 1'b0);
      tick(3);
   endtask
   // Main sequence
   initial begin
      nrst = 1'b0;
      req = 1'b0;
      req_write = 1'b0;
      req_index = 16'h0000;
      req_wdata = 16'h0000;
      op_mode = `DCS_MODE_PP;
      dv = 12'h000;
      acode = 16'h0000;
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      tick(3);
      cmp(status_word_q, 16'h0040);
      rdc(`DCS_IDX_ALARM, 16'h0000, 1'b0);
      rdc(`DCS_IDX_CMD, 16'h0000, 1'b0);
      @(posedge clk_sys);
      dv[6:1] <= 6'h3D;
      @(posedge clk_sys);
      dv[1] <= 1'b0;
      tick(3);
      cmp(status_word_q, 16'h4AD0);
      cmd(16'h0080);
      cmp(status_word_q, 16'h4A50);
      cmd(16'h0080);
      cmp(16'(n_clr), 16'h0001);
      for (int i = 0; i < 8; i++) begin
         cmd(SC[i]);
         cmp(status_word_q, SE[i]);
      end
      cmp(16'(power_stage_q), 16'h0001);
      cmd(16'h000B);
      cmp(status_word_q, 16'h4A17);
      @(posedge clk_sys);
      dv[7] <= 1'b1;
      tick(3);
      cmp(status_word_q, 16'h4A50);
      @(posedge clk_sys);
      dv[7] <= 1'b0;
      cmd(16'h0006);
      cmd(16'h000F);
      @(posedge clk_sys);
      dv[0] <= 1'b1;
      acode <= 16'h1234;
      @(posedge clk_sys);
      dv[0] <= 1'b0;
      tick(3);
      cmp(status_word_q, 16'h4A1F);
      wr(`DCS_IDX_ALARM, 16'h5555, 1'b1);
      rdc(`DCS_IDX_ALARM, 16'h1234, 1'b0);
      wr(`DCS_IDX_STATE, 16'hFFFF, 1'b1);
      rdc(16'h6060, 16'h0000, 1'b1);
      @(posedge clk_sys);
      dv[2] <= 1'b1;
      @(posedge clk_sys);
      dv[2] <= 1'b0;
      tick(3);
      cmp(status_word_q, 16'h4A18);
      cmd(16'h0080);
      rdc(`DCS_IDX_STATE, 16'h4A50, 1'b0);
      cmp(16'(n_clr), 16'h0002);
      cmd(16'h0006);
      cmd(16'h000F);
      cmd(16'h001F);
      cmp(status_word_q, 16'h5A37);
      cmp(16'({n_st[3:0], n_imm[3:0], n_fin[3:0]}), 16'h0100);
      cmd(16'h000F);
      cmp(status_word_q, 16'h4A37);
      cmd(16'h003F);
      cmp(status_word_q, 16'h5A37);
      // Completed move drops the acknowledge while bit 4 is still held
      @(posedge clk_sys);
      dv[10] <= 1'b1;
      @(posedge clk_sys);
      dv[10] <= 1'b0;
      tick(3);
      cmp(status_word_q, 16'h4A37);
      cmd(16'h000F);
      cmd(16'h023F);
      cmd(16'h000F);
      cmd(16'h021F);
      cmp(16'({n_imm[3:0], n_fin[3:0]}), 16'h0021);
      cmd(16'h004F);
      cmp(16'(sp_relative_q), 16'h0001);
      rdc(`DCS_IDX_CMD, 16'h004F, 1'b0);
      for (int i = 0; i < 7; i++) begin
         @(posedge clk_sys);
         op_mode <= MD[i];
         cmd(16'h010F);
         cmp(16'(halt_q), 16'h0001);
         cmd(16'h000F);
         cmp(16'(halt_q), 16'h0000);
      end
      cmd(16'h001F);
      cmp(16'(homing_run_q), 16'h0001);
      cmp(status_word_q, 16'h4A37);
      // Homing done but target not reached, then completed
      @(posedge clk_sys);
      dv[8] <= 1'b1;
      tick(3);
      cmp(status_word_q, 16'h5A37);
      @(posedge clk_sys);
      dv[11] <= 1'b1;
      tick(3);
      cmp(status_word_q, 16'h5E37);
      @(posedge clk_sys);
      dv[9:8] <= 2'b10;
      tick(3);
      cmp(status_word_q, 16'h6A37);
      @(posedge clk_sys);
      dv[7] <= 1'b1;
      tick(3);
      cmp(status_word_q, 16'h6E37);
      @(posedge clk_sys);
      dv[9] <= 1'b0;
      dv[7] <= 1'b0;
      cmd(16'h000F);
      cmp(status_word_q, 16'h4E37);
      wr(`DCS_IDX_CMD, 16'hFFFF, 1'b0);
      rdc(`DCS_IDX_CMD, 16'hFFFF, 1'b0);
      finish_test;
   end
   // Cut a hang short well past the expected run length
   initial begin
      repeat (5000) @(posedge clk_sys);
      err_count++;
      finish_test;
   end
endmodule // drive_control_status_word_tb
